// ==== common/pmc_pkg.sv ====
// constants, field layout and types of the power manager register block
// Functional notes
// - core clock status bit resets to one
// - enable register sets peripheral clock bits
// - disable register clears peripheral clock bits
// - status shows peripheral clocks, zero at reset
// - fixed peripheral bit positions, others unused
// - bypass bit picks crystal or external clock
// - oscillator enable bit, mode resets zero
// - output disable bit tri-states clock pin
// - prescaler divides by powers of two
// - zero factor stops PLL, else multiplies
// - two-bit clock source selection codes
// - startup counter loads on enable, slow/8
// - lock counter loads on factor change
// - shutdown command applies shutdown selection
// - wake command applies wake selection
// - wake command wins when both written
// - pin code: float, low, high, reserved
// - stable flag set when startup count ends
// - lock flag set when lock count ends
package pmc_pkg;

   localparam logic [7:0] SYS_CLOCK_ENABLE_OFF     = 8'h00;
   localparam logic [7:0] SYS_CLOCK_DISABLE_OFF    = 8'h04;
   localparam logic [7:0] SYSTEM_CLOCK_STATE_OFF   = 8'h08;
   localparam logic [7:0] PERIPH_CLOCK_ENABLE_OFF  = 8'h10;
   localparam logic [7:0] PERIPH_CLOCK_DISABLE_OFF = 8'h14;
   localparam logic [7:0] PERIPH_CLOCK_STATE_OFF   = 8'h18;
   localparam logic [7:0] CLOCK_GENERATOR_MODE_OFF = 8'h20;
   localparam logic [7:0] POWER_COMMAND_OFF        = 8'h28;
   localparam logic [7:0] POWER_MODE_OFF           = 8'h2c;
   localparam logic [7:0] POWER_STATUS_OFF         = 8'h30;

   localparam int SERIAL0_CLOCK_BIT       = 2;
   localparam int TIMER0_CLOCK_BIT        = 6;
   localparam int TIMER5_CLOCK_BIT        = 11;
   localparam int PORT_A_CLOCK_BIT        = 13;
   localparam int ANALOG_OUT1_CLOCK_BIT   = 18;
   localparam logic [31:0] PERIPH_MASK    = 32'h0007effc;

   localparam int OSC_BYPASS_BIT          = 0;
   localparam int OSC_ENABLE_BIT          = 1;
   localparam int CLOCK_OUT_DISABLE_BIT   = 2;
   localparam int DIVIDER_SELECT_LSB      = 4;
   localparam int PLL_FACTOR_LSB          = 8;
   localparam int SOURCE_SELECT_LSB       = 14;
   localparam int OSC_STARTUP_COUNT_LSB   = 16;
   localparam int PLL_LOCK_COUNT_LSB      = 24;
   localparam logic [31:0] MODE_MASK      = 32'h3fffff77;
   localparam logic [31:0] MODE_RESET     = 32'h00000000;

   localparam int SHUTDOWN_COMMAND_BIT    = 0;
   localparam int WAKE_ACK_COMMAND_BIT    = 1;
   localparam int SHUTDOWN_SELECT_LSB     = 0;
   localparam int WAKE_ACK_SELECT_LSB     = 2;
   localparam logic [3:0] POWER_MODE_RESET = 4'h1;
   localparam int STABLE_FLAG_BIT         = 0;
   localparam int LOCK_FLAG_BIT           = 1;

   localparam logic [1:0] SRC_SLOW        = 2'h0;
   localparam logic [1:0] SRC_MAIN_OSC    = 2'h1;
   localparam logic [1:0] SRC_PLL         = 2'h2;
   localparam logic [2:0] DIV_RESERVED    = 3'h7;

   localparam logic [1:0] PIN_CODE_FLOAT  = 2'h0;
   localparam logic [1:0] PIN_CODE_LOW    = 2'h1;
   localparam logic [1:0] PIN_CODE_HIGH   = 2'h2;

   localparam int SLOW_CLOCK_HZ           = 32768;
   localparam int SYS_CLOCK_HZ            = 10000000;
   localparam int STARTUP_TICK_DIV        = 8;

   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;

   typedef enum logic [2:0] {
      PIN_FLOAT      = 3'h1,
      PIN_DRIVE_LOW  = 3'h2,
      PIN_DRIVE_HIGH = 3'h4
   } pmc_pin_state_t;

endpackage

// ==== rtl/pmc_power_manager.sv ====
// power manager: clock enables, clock generator, shutdown pin, axi-lite
//
// Register access over AXI4-Lite was left to the implementer.
module pmc_power_manager
   import pmc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        slow_clock_in,
   output      logic        core_clock_run,
   output      logic [31:0] periph_clock_en,
   output      logic        oscillator_enable,
   output      logic        oscillator_bypass,
   output      logic        osc_output_pin_oe,
   output      logic [5:0]  pll_factor,
   output      logic [1:0]  clock_source_select,
   output      logic        master_clock,
   output      logic        clock_output_pin_out,
   output      logic        clock_output_pin_oe,
   output      logic        power_off_pin_out,
   output      logic        power_off_pin_oe
);

   function automatic logic pmc_mapped(input logic [7:0] a);
      case (a)
         SYS_CLOCK_ENABLE_OFF, SYS_CLOCK_DISABLE_OFF,
         SYSTEM_CLOCK_STATE_OFF, PERIPH_CLOCK_ENABLE_OFF,
         PERIPH_CLOCK_DISABLE_OFF, PERIPH_CLOCK_STATE_OFF,
         CLOCK_GENERATOR_MODE_OFF, POWER_COMMAND_OFF,
         POWER_MODE_OFF, POWER_STATUS_OFF: pmc_mapped = 1'b1;
         default:                          pmc_mapped = 1'b0;
      endcase
   endfunction

   function automatic pmc_pin_state_t pmc_pin_decode(input logic [1:0] c);
      case (c)
         PIN_CODE_LOW:  pmc_pin_decode = PIN_DRIVE_LOW;
         PIN_CODE_HIGH: pmc_pin_decode = PIN_DRIVE_HIGH;
         // reserved code is taken as float, the safe pin state
         default:       pmc_pin_decode = PIN_FLOAT;
      endcase
   endfunction

   logic [7:0]     aw_addr_reg;
   logic           aw_held_reg;
   logic [31:0]    w_data_reg;
   logic [3:0]     w_strb_reg;
   logic           w_held_reg;
   logic           core_run_reg;
   logic [31:0]    periph_reg;
   logic [31:0]    mode_reg;
   logic [3:0]     pmode_reg;
   pmc_pin_state_t pin_state_reg;
   logic [2:0]     slow_sync_reg;
   logic [2:0]     slow_div_reg;
   logic [7:0]     osc_cnt_reg;
   logic           stable_reg;
   logic [5:0]     pll_cnt_reg;
   logic           lock_reg;
   logic [5:0]     clock_divider_select_cnt_reg;
   logic           mclk_reg;
   logic           clk_pin_reg;
   logic           do_write;
   logic [31:0]    wval;
   logic           slow_tick;
   logic           startup_tick;
   logic           mode_wr;
   logic           src_tick;
   logic [5:0]     clock_divider_select_limit;

   ////////////////////////////////////////////////////////////////////////
   // axi-lite write side: address and data latched in either order

   assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
   assign wval     = w_data_reg & {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                                   {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg   <= 1'b0;
         aw_addr_reg   <= 8'h00;
         s_axi_awready <= 1'b1;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg   <= 1'b1;
         aw_addr_reg   <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         aw_held_reg   <= 1'b0;
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg   <= 1'b0;
         w_data_reg   <= 32'h00000000;
         w_strb_reg   <= 4'h0;
         s_axi_wready <= 1'b1;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg   <= 1'b1;
         w_data_reg   <= s_axi_wdata;
         w_strb_reg   <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         w_held_reg   <= 1'b0;
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= pmc_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi-lite read side, one cycle to answer

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= pmc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            SYSTEM_CLOCK_STATE_OFF:   s_axi_rdata <= {31'h0, core_run_reg};
            PERIPH_CLOCK_STATE_OFF:   s_axi_rdata <= periph_reg;
            CLOCK_GENERATOR_MODE_OFF: s_axi_rdata <= mode_reg;
            POWER_MODE_OFF:           s_axi_rdata <= {28'h0, pmode_reg};
            POWER_STATUS_OFF:         s_axi_rdata <= {30'h0, lock_reg,
                                                      stable_reg};
            default:                  s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock enable registers

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_run_reg <= 1'b1;
      end else if (do_write && aw_addr_reg == SYS_CLOCK_ENABLE_OFF &&
                   wval[0]) begin
         core_run_reg <= 1'b1;
      end else if (do_write && aw_addr_reg == SYS_CLOCK_DISABLE_OFF &&
                   wval[0]) begin
         core_run_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periph_reg <= 32'h00000000;
      end else if (do_write && aw_addr_reg == PERIPH_CLOCK_ENABLE_OFF) begin
         periph_reg <= periph_reg | (wval & PERIPH_MASK);
      end else if (do_write && aw_addr_reg == PERIPH_CLOCK_DISABLE_OFF) begin
         periph_reg <= periph_reg & ~(wval & PERIPH_MASK);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clock generator mode and power mode registers

   assign mode_wr = do_write && aw_addr_reg == CLOCK_GENERATOR_MODE_OFF;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= MODE_RESET;
      end else if (mode_wr) begin
         mode_reg <= wval & MODE_MASK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pmode_reg <= POWER_MODE_RESET;
      end else if (do_write && aw_addr_reg == POWER_MODE_OFF) begin
         pmode_reg <= wval[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // slow clock sampling; stage 0 feeds stage 1 only

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_sync_reg <= 3'h0;
      end else begin
         slow_sync_reg <= {slow_sync_reg[1:0], slow_clock_in};
      end
   end

   assign slow_tick    = slow_sync_reg[1] && !slow_sync_reg[2];
   assign startup_tick = slow_tick && slow_div_reg == 3'h7;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_div_reg <= 3'h0;
      end else if (slow_tick) begin
         slow_div_reg <= slow_div_reg + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // oscillator start-up and pll lock counters

   // load on enable set, count slow/8
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_cnt_reg <= 8'h00;
         stable_reg  <= 1'b0;
      end else if (mode_wr && !wval[OSC_ENABLE_BIT]) begin
         osc_cnt_reg <= 8'h00;
         stable_reg  <= 1'b0;
      end else if (mode_wr && !mode_reg[OSC_ENABLE_BIT]) begin
         osc_cnt_reg <= wval[OSC_STARTUP_COUNT_LSB +: 8];
         stable_reg  <= wval[OSC_STARTUP_COUNT_LSB +: 8] == 8'h00;
      end else if (startup_tick && osc_cnt_reg != 8'h00) begin
         osc_cnt_reg <= osc_cnt_reg - 8'h01;
         if (osc_cnt_reg == 8'h01) begin
            stable_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pll_cnt_reg <= 6'h00;
         lock_reg    <= 1'b0;
      end else if (mode_wr && wval[PLL_FACTOR_LSB +: 6] !=
                   mode_reg[PLL_FACTOR_LSB +: 6]) begin
         if (wval[PLL_FACTOR_LSB +: 6] == 6'h00) begin
            pll_cnt_reg <= 6'h00;
            lock_reg    <= 1'b0;
         end else if (wval[PLL_LOCK_COUNT_LSB +: 6] != 6'h00) begin
            pll_cnt_reg <= wval[PLL_LOCK_COUNT_LSB +: 6];
            lock_reg    <= 1'b0;
         end
      end else if (slow_tick && pll_cnt_reg != 6'h00) begin
         pll_cnt_reg <= pll_cnt_reg - 6'h01;
         if (pll_cnt_reg == 6'h01) begin
            lock_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // master clock enable: source tick, then prescaler

   // source choice; reserved and unready give no tick
   always_comb begin
      src_tick = 1'b0;
      case (mode_reg[SOURCE_SELECT_LSB +: 2])
         SRC_SLOW:     src_tick = slow_tick;
         SRC_MAIN_OSC: src_tick = stable_reg;
         SRC_PLL:      src_tick = lock_reg &&
                                  mode_reg[PLL_FACTOR_LSB +: 6] != 6'h00;
         default:      src_tick = 1'b0;
      endcase
   end

   // divide by two to the field
   assign clock_divider_select_limit = 6'((7'h1 << mode_reg[DIVIDER_SELECT_LSB +: 3]) - 7'h1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_divider_select_cnt_reg <= 6'h00;
         mclk_reg     <= 1'b0;
      end else begin
         mclk_reg <= 1'b0;
         if (src_tick &&
             mode_reg[DIVIDER_SELECT_LSB +: 3] != DIV_RESERVED) begin
            if (clock_divider_select_cnt_reg >= clock_divider_select_limit) begin
               clock_divider_select_cnt_reg <= 6'h00;
               mclk_reg     <= 1'b1;
            end else begin
               clock_divider_select_cnt_reg <= clock_divider_select_cnt_reg + 6'h01;
            end
         end
      end
   end

   // pin shows a square wave at half the enable rate
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_pin_reg <= 1'b0;
      end else if (mclk_reg) begin
         clk_pin_reg <= !clk_pin_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shutdown pin state, kept until the next command

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_state_reg <= PIN_FLOAT;
      end else if (do_write && aw_addr_reg == POWER_COMMAND_OFF) begin
         if (wval[WAKE_ACK_COMMAND_BIT]) begin
            pin_state_reg <= pmc_pin_decode(pmode_reg[WAKE_ACK_SELECT_LSB +: 2]);
         end else if (wval[SHUTDOWN_COMMAND_BIT]) begin
            pin_state_reg <= pmc_pin_decode(pmode_reg[SHUTDOWN_SELECT_LSB +: 2]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_off_pin_out <= 1'b0;
         power_off_pin_oe  <= 1'b0;
      end else begin
         case (pin_state_reg)
            PIN_DRIVE_LOW: begin
               power_off_pin_out <= 1'b0;
               power_off_pin_oe  <= 1'b1;
            end
            PIN_DRIVE_HIGH: begin
               power_off_pin_out <= 1'b1;
               power_off_pin_oe  <= 1'b1;
            end
            default: begin
               power_off_pin_out <= 1'b0;
               power_off_pin_oe  <= 1'b0;
            end
         endcase
      end
   end

   // outputs lag their registers by one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_clock_run       <= 1'b1;
         periph_clock_en      <= 32'h00000000;
         oscillator_enable    <= 1'b0;
         oscillator_bypass    <= 1'b0;
         osc_output_pin_oe    <= 1'b0;
         pll_factor           <= 6'h00;
         clock_source_select  <= SRC_SLOW;
         master_clock         <= 1'b0;
         clock_output_pin_out <= 1'b0;
         clock_output_pin_oe  <= 1'b0;
      end else begin
         core_clock_run       <= core_run_reg;
         periph_clock_en      <= periph_reg;
         oscillator_enable    <= mode_reg[OSC_ENABLE_BIT];
         oscillator_bypass    <= mode_reg[OSC_BYPASS_BIT];
         osc_output_pin_oe    <= mode_reg[OSC_ENABLE_BIT] &&
                                 !mode_reg[OSC_BYPASS_BIT];
         pll_factor           <= mode_reg[PLL_FACTOR_LSB +: 6];
         clock_source_select  <= mode_reg[SOURCE_SELECT_LSB +: 2];
         master_clock         <= mclk_reg;
         clock_output_pin_out <= clk_pin_reg;
         clock_output_pin_oe  <= !mode_reg[CLOCK_OUT_DISABLE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   // write value one cycle late, for the post-write checks
   logic [31:0] wval_q;
   always_ff @(posedge aclk) begin
      wval_q <= wval;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   periph_set_a: assert property (do_write && aw_addr_reg ==
      PERIPH_CLOCK_ENABLE_OFF |=> (periph_reg & wval_q & PERIPH_MASK) ==
      (wval_q & PERIPH_MASK)) else $error("enable bit not set");
   periph_clr_a: assert property (do_write && aw_addr_reg ==
      PERIPH_CLOCK_DISABLE_OFF |=> (periph_reg & wval_q) == 32'h0)
      else $error("disable bit not cleared");
   periph_mask_a: assert property ((periph_clock_en & ~PERIPH_MASK) == 32'h0)
      else $error("unused peripheral bit set");
   pin_wake_a: assert property (do_write && aw_addr_reg == POWER_COMMAND_OFF
      && wval[WAKE_ACK_COMMAND_BIT] |=> pin_state_reg ==
      pmc_pin_decode($past(pmode_reg[WAKE_ACK_SELECT_LSB +: 2])))
      else $error("wake state not applied");
   pin_drive_a: assert property (pin_state_reg == PIN_DRIVE_HIGH |=>
      power_off_pin_oe && power_off_pin_out)
      else $error("pin not driven high");
   osc_stable_a: assert property (startup_tick && osc_cnt_reg == 8'h01 &&
      !mode_wr |=> stable_reg) else $error("stable flag missing");
   pll_lock_a: assert property (slow_tick && pll_cnt_reg == 6'h01 &&
      !mode_wr |=> lock_reg) else $error("lock flag missing");
   pll_load_a: assert property (mode_wr && wval[PLL_FACTOR_LSB +: 6] !=
      mode_reg[PLL_FACTOR_LSB +: 6] && wval[PLL_FACTOR_LSB +: 6] != 6'h0 &&
      wval[PLL_LOCK_COUNT_LSB +: 6] != 6'h0 |=> !lock_reg ##0
      pll_cnt_reg == $past(wval[PLL_LOCK_COUNT_LSB +: 6]))
      else $error("lock counter not loaded");
   wr_resp_a: assert property (do_write |=> s_axi_bvalid)
      else $error("write response missing");
   rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer missing");

   shut_cover_c: cover property (power_off_pin_oe ##[1:50] !power_off_pin_oe);
   lock_cover_c: cover property ($rose(lock_reg));
   mclk_cover_c: cover property (master_clock ##[1:100] master_clock);

endmodule // pmc_power_manager

// ==== sim/pmc_power_manager_tb.sv ====
// self-checking bench for the power manager register block
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin \
   fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module pmc_power_manager_tb
   import pmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, periph_clock_en, rd;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, slow_clock_in, core_clock_run;
   logic [1:0]  s_axi_bresp, s_axi_rresp, clock_source_select, resp;
   logic        oscillator_enable, oscillator_bypass, osc_output_pin_oe;
   logic        master_clock, clock_output_pin_out, clock_output_pin_oe;
   logic        power_off_pin_out, power_off_pin_oe;
   logic [5:0]  pll_factor;
   int          tests_run = 0, fail_count = 0;

   pmc_power_manager pmc_power_manager_inst (.*);
   pmc_slow_clock_model pmc_slow_clock_model_inst (.slow_clock_in);

   always #50 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic timed_out();
      fail_count++;
      report_and_stop();
   endtask

   // valid and payload held until each channel's own ready edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 40) timed_out();
   endtask

   task automatic rd_reg(input logic [7:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 40) timed_out();
   endtask

   task automatic wait_flag(input int b);
      int n;
      for (n = 0; n < 100; n++) begin
         rd_reg(POWER_STATUS_OFF);
         if (rd[b] === 1'b1) break;
      end
      if (n == 100) timed_out();
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd_reg(SYSTEM_CLOCK_STATE_OFF);
      `CHK("core_state", 32'h1, rd)
      `CHK("core_run", 1'b1, core_clock_run)
      rd_reg(PERIPH_CLOCK_STATE_OFF);
      `CHK("periph_rst", 32'h0, rd)
      rd_reg(CLOCK_GENERATOR_MODE_OFF);
      `CHK("mode_rst", MODE_RESET, rd)
      rd_reg(PERIPH_CLOCK_ENABLE_OFF);
      `CHK("wo_read", 32'h0, rd)
      rd_reg(8'h3c);
      `CHK("unmapped", RESP_SLVERR, resp)
      `CHK("pin_float", 1'b0, power_off_pin_oe)
      $display("test reset done");
   endtask

   task automatic t_periph();
      wr(PERIPH_CLOCK_ENABLE_OFF, 32'hffffffff);
      rd_reg(PERIPH_CLOCK_STATE_OFF);
      `CHK("periph_all", PERIPH_MASK, rd)
      wr(PERIPH_CLOCK_DISABLE_OFF, 32'h00000804);
      wr(PERIPH_CLOCK_ENABLE_OFF, 32'h0);
      rd_reg(PERIPH_CLOCK_STATE_OFF);
      `CHK("periph_clr", PERIPH_MASK & ~32'h804, rd)
      wr(PERIPH_CLOCK_DISABLE_OFF, 32'h0);
      `CHK("periph_pin", PERIPH_MASK & ~32'h804, periph_clock_en)
      $display("test periph done");
   endtask

   task automatic t_mode();
      wr(CLOCK_GENERATOR_MODE_OFF, 32'hc00040ad);
      rd_reg(CLOCK_GENERATOR_MODE_OFF);
      `CHK("mode_rb", 32'h00004025, rd)
      `CHK("bypass", 1'b1, oscillator_bypass)
      `CHK("xtal_oe", 1'b0, osc_output_pin_oe)
      `CHK("clock_output_pin_off", 1'b0, clock_output_pin_oe)
      `CHK("src", SRC_MAIN_OSC, clock_source_select)
      $display("test mode done");
   endtask

   task automatic t_clocks();
      int i, k, cnt;
      logic [4:0] s [6] = '{5'h08, 5'h09, 5'h0a, 5'h10, 5'h18, 5'h0f};
      int e [6] = '{40, 20, 10, 40, 0, 0};
      wr(CLOCK_GENERATOR_MODE_OFF, 32'h00020002);
      rd_reg(POWER_STATUS_OFF);
      `CHK("stable_early", 1'b0, rd[STABLE_FLAG_BIT])
      wait_flag(STABLE_FLAG_BIT);
      `CHK("osc_en", 1'b1, oscillator_enable)
      wr(CLOCK_GENERATOR_MODE_OFF, 32'h02010302);
      rd_reg(POWER_STATUS_OFF);
      `CHK("lock_early", 1'b0, rd[LOCK_FLAG_BIT])
      wait_flag(LOCK_FLAG_BIT);
      `CHK("factor", 6'h3, pll_factor)
      for (i = 0; i < 6; i++) begin
         wr(CLOCK_GENERATOR_MODE_OFF,
            32'h02010302 | {16'h0, s[i][4:3], 7'h0, s[i][2:0], 4'h0});
         repeat (2) @(posedge aclk);
         cnt = 0;
         for (k = 0; k < 40; k++) begin
            @(posedge aclk);
            if (master_clock === 1'b1) cnt++;
         end
         `CHK("mck_pulses", e[i], cnt)
      end
      `CHK("clock_output_pin_on", 1'b1, clock_output_pin_oe)
      $display("test clocks done");
   endtask

   task automatic t_power();
      wr(POWER_MODE_OFF, 32'h6);
      wr(POWER_COMMAND_OFF, 32'h1);
      repeat (3) @(posedge aclk);
      `CHK("shd_oe", 1'b1, power_off_pin_oe)
      `CHK("shd_hi", 1'b1, power_off_pin_out)
      wr(POWER_COMMAND_OFF, 32'h2);
      repeat (3) @(posedge aclk);
      `CHK("wake_lo", 1'b0, power_off_pin_out)
      wr(POWER_COMMAND_OFF, 32'h1);
      wr(POWER_COMMAND_OFF, 32'h3);
      repeat (3) @(posedge aclk);
      `CHK("both_wake", 1'b0, power_off_pin_out)
      wr(POWER_MODE_OFF, 32'h2);
      wr(POWER_COMMAND_OFF, 32'h0);
      repeat (3) @(posedge aclk);
      `CHK("no_effect", 1'b1, power_off_pin_oe)
      wr(POWER_COMMAND_OFF, 32'h2);
      repeat (3) @(posedge aclk);
      `CHK("wake_float", 1'b0, power_off_pin_oe)
      $display("test power done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_periph();
      t_mode();
      t_clocks();
      t_power();
      report_and_stop();
   end
endmodule // pmc_power_manager_tb

// ==== sim/pmc_slow_clock_model.sv ====
// slow clock source model for the power manager bench
module pmc_slow_clock_model #(
   parameter int HALF_NS = 430
) (
   output logic slow_clock_in
);
   timeunit 1ns;
   timeprecision 1ns;
   ////////////////////////////////////////////////////////////////////////
   // free running; phase unrelated to aclk so the synchroniser is exercised
   initial begin
      slow_clock_in = 1'b0;
      forever #(HALF_NS) slow_clock_in = ~slow_clock_in;
   end
endmodule // pmc_slow_clock_model
